// ---- rtl/rss_reset_sequencer.sv ----
// Reset and start-up sequencer: merges reset sources, runs the
// start-up delays, records the cause and handles sleep wake-up.
// Assumes rst_b is the power-on reset and all pins are synchronous.
`timescale 1ns/1ps
module rss_reset_sequencer
    import rss_pkg::*;
#(
    parameter int unsigned POWER_UP_DELAY_TIMER_COUNT = POWER_UP_DELAY_TIMER_CYCLES,
    parameter int unsigned OST_COUNT  = OST_CYCLES,
    parameter int unsigned BOR_COUNT  = BOR_QUAL_CYCLES,
    parameter int unsigned MASTER_CLEAR_INPUT_COUNT = MASTER_CLEAR_INPUT_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        master_clear_input_b,
    input  wire logic        supply_above_threshold,
    input  wire logic        watchdog_timer_event,
    input  wire logic        sleep_enter,
    input  wire logic        interrupt_wake,
    input  wire logic        clear_watchdog_cmd,
    input  wire logic        sw_brown_out_enable,
    input  wire logic        prog_mode,
    input  wire logic        prog_write,
    input  wire logic        prog_bulk_erase,
    input  wire logic [13:0] prog_addr,
    input  wire logic [13:0] prog_wdata,
    output logic      [13:0] prog_rdata,
    output logic             core_reset,
    output logic             reg_reset,
    output logic             core_sleeping,
    output logic             brown_out_active,
    output logic             time_out_flag,
    output logic             power_down_flag,
    output rss_cause_t       reset_cause
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    rss_state_t    state;
    rss_state_t    next_state;
    rss_bor_mode_t bor_mode;
    logic [13:0]   cfg_word;
    logic [13:0]   cal_word;
    logic          power_up_delay_enable;
    logic          xtal_mode;
    logic          bor_enabled;
    logic          bor_event;
    logic          master_clear_input_event;
    logic          active;
    logic          reset_path;
    logic          next_reset_path;

    rss_tmr_if power_up_delay_timer_if (.clk(clk));
    rss_tmr_if ost_if (.clk(clk));

    // ==========================================================
    // Configuration and calibration words
    // Nonvolatile: no reset, they keep their value across every reset.
    always_ff @(posedge clk) begin
        if (prog_mode && prog_bulk_erase) begin
            cfg_word <= WORD_ERASED;
        end else if (prog_mode && prog_write
                     && prog_addr == CFG_WORD_ADDR) begin
            cfg_word <= prog_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (prog_mode && !prog_bulk_erase && prog_write
            && prog_addr == CAL_WORD_ADDR) begin
            cal_word <= prog_wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b || !prog_mode) begin
            prog_rdata <= WORD_ZERO;
        end else if (prog_addr == CFG_WORD_ADDR) begin
            prog_rdata <= cfg_word;
        end else if (prog_addr == CAL_WORD_ADDR) begin
            prog_rdata <= cal_word;
        end else begin
            prog_rdata <= WORD_ZERO;
        end
    end

    // A programmed bit reads zero, so the delay and crystal options are active low here; the BOREN field is used as read
    assign power_up_delay_enable = !cfg_word[CFG_POWER_UP_DELAY_ENABLE_BIT];
    assign xtal_mode             = !cfg_word[CFG_XTAL_BIT];
    assign bor_mode = rss_bor_mode_t'(cfg_word[CFG_BOREN_HI:CFG_BOREN_LO]);

    // ==========================================================
    // Brown-out enable and input filters
    always_comb begin
        case (bor_mode)
            BOR_ON:      bor_enabled = 1'b1;
            BOR_NOSLEEP: bor_enabled = (state != ST_SLEEP);
            BOR_SW:      bor_enabled = sw_brown_out_enable;
            default:     bor_enabled = 1'b0;
        endcase
    end

    rss_pulse_filter #(.WIDTH(BOR_COUNT)) u_bor_filt (
        .clk       (clk),
        .rst_b     (rst_b),
        .level_in  (bor_enabled && !supply_above_threshold),
        .level_out (bor_event)
    );

    rss_pulse_filter #(.WIDTH(MASTER_CLEAR_INPUT_COUNT)) u_master_clear_input_filt (
        .clk       (clk),
        .rst_b     (rst_b),
        .level_in  (!master_clear_input_b),
        .level_out (master_clear_input_event)
    );

    // ==========================================================
    // Start-up timers
    assign power_up_delay_timer_if.run = (state == ST_POWER_UP_DELAY_TIMER);
    assign ost_if.run  = (state == ST_OST);

    rss_delay_timer #(.COUNT(POWER_UP_DELAY_TIMER_COUNT)) u_power_up_delay_timer (
        .t     (power_up_delay_timer_if.tmr),
        .rst_b (rst_b)
    );

    rss_delay_timer #(.COUNT(OST_COUNT)) u_ost (
        .t     (ost_if.tmr),
        .rst_b (rst_b)
    );

    // ==========================================================
    // Sequencer state
    assign active = (state == ST_RUN) || (state == ST_SLEEP);

    always_comb begin
        next_state      = state;
        next_reset_path = reset_path;
        case (state)
            ST_SUPPLY: begin
                if (supply_above_threshold && !master_clear_input_event) begin
                    if (power_up_delay_enable) begin
                        next_state = ST_POWER_UP_DELAY_TIMER;
                    end else if (xtal_mode) begin
                        next_state = ST_OST;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_POWER_UP_DELAY_TIMER: begin
                if (!supply_above_threshold) begin
                    next_state = ST_SUPPLY;
                end else if (power_up_delay_timer_if.done) begin
                    next_state = xtal_mode ? ST_OST : ST_RUN;
                end
            end
            ST_OST: begin
                if (ost_if.done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (sleep_enter) begin
                    next_state = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (interrupt_wake || watchdog_timer_event) begin
                    next_state = xtal_mode ? ST_OST : ST_RUN;
                end
            end
            default: next_state = ST_SUPPLY;
        endcase
        // Master-clear and brown-out override every step of the sequence; the watchdog resets only from ST_RUN
        if (master_clear_input_event || bor_event
            || (state == ST_RUN && watchdog_timer_event)) begin
            next_state      = ST_SUPPLY;
            next_reset_path = 1'b1;
        end else if (next_state == ST_RUN) begin
            next_reset_path = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state      <= ST_SUPPLY;
            reset_path <= 1'b1;
        end else begin
            state      <= next_state;
            reset_path <= next_reset_path;
        end
    end

    // ==========================================================
    // Outputs
    // Unaffected-class registers take no reset from this block at all
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            core_reset       <= 1'b1;
            reg_reset        <= 1'b1;
            core_sleeping    <= 1'b0;
            brown_out_active <= 1'b0;
        end else begin
            core_reset <= (next_state != ST_RUN)
                          && (next_state != ST_SLEEP);
            reg_reset  <= next_reset_path && (next_state != ST_RUN)
                          && (next_state != ST_SLEEP);
            core_sleeping    <= (next_state == ST_SLEEP);
            brown_out_active <= bor_enabled;
        end
    end

    // Causes are only taken from a running or sleeping core, so a held
    // pin or low supply during start-up keeps the first cause.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reset_cause     <= CAUSE_POR;
            time_out_flag   <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (active && master_clear_input_event) begin
            if (state == ST_SLEEP) begin
                reset_cause     <= CAUSE_MASTER_CLEAR_INPUT_SLEEP;
                time_out_flag   <= 1'b1;
                power_down_flag <= 1'b0;
            end else begin
                reset_cause <= CAUSE_MASTER_CLEAR_INPUT_RUN;
            end
        end else if (active && bor_event) begin
            reset_cause     <= CAUSE_BOR;
            time_out_flag   <= 1'b1;
            power_down_flag <= 1'b1;
        end else if (active && watchdog_timer_event) begin
            time_out_flag <= 1'b0;
            if (state == ST_SLEEP) begin
                reset_cause     <= CAUSE_WDT_SLEEP;
                power_down_flag <= 1'b0;
            end else begin
                reset_cause <= CAUSE_WDT_RUN;
            end
        end else if (state == ST_SLEEP && interrupt_wake) begin
            reset_cause     <= CAUSE_INT_WAKE;
            time_out_flag   <= 1'b1;
            power_down_flag <= 1'b0;
        end else if (state == ST_RUN && sleep_enter) begin
            time_out_flag   <= 1'b1;
            power_down_flag <= 1'b0;
        end else if (state == ST_RUN && clear_watchdog_cmd) begin
            time_out_flag   <= 1'b1;
            power_down_flag <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    sequence s_wdt_wake;
        state == ST_SLEEP && watchdog_timer_event
        && !master_clear_input_event && !bor_event;
    endsequence

    sequence s_quiet_flags;
        !reg_reset && !time_out_flag && !power_down_flag;
    endsequence

    a_power_up_delay_timer_restart: assert property (
        (state == ST_POWER_UP_DELAY_TIMER && !supply_above_threshold)
        |=> state == ST_SUPPLY ##1 core_reset)
        else $error("supply dip did not restart the delay");
    a_power_up_delay_timer_full: assert property (
        (state == ST_POWER_UP_DELAY_TIMER && next_state != ST_POWER_UP_DELAY_TIMER
         && next_state != ST_SUPPLY) |-> power_up_delay_timer_if.done)
        else $error("power-up delay ended early");
    a_ost_wait: assert property (
        (state == ST_OST && !ost_if.done && !master_clear_input_event && !bor_event)
        |=> state == ST_OST)
        else $error("left start-up wait before stable");
    a_supply_hold: assert property (
        (state == ST_SUPPLY && !supply_above_threshold)
        |=> core_reset && state == ST_SUPPLY)
        else $error("released before supply recovered");
    a_wdt_wake: assert property (
        s_wdt_wake |=> s_quiet_flags ##0 reset_cause == CAUSE_WDT_SLEEP)
        else $error("watchdog wake reset registers or flags wrong");
    a_int_wake: assert property (
        (state == ST_SLEEP && interrupt_wake && !watchdog_timer_event
         && !master_clear_input_event && !bor_event)
        |=> !core_sleeping && time_out_flag && !power_down_flag)
        else $error("interrupt did not wake the core");
    a_bor_sleep: assert property (
        (bor_mode == BOR_NOSLEEP && state == ST_SLEEP) |-> !bor_enabled)
        else $error("brown-out detection left on in sleep");
    a_power_up_delay_enable_off: assert property (
        (state == ST_SUPPLY && supply_above_threshold && !master_clear_input_event
         && !bor_event && cfg_word[CFG_POWER_UP_DELAY_ENABLE_BIT]) |=> state != ST_POWER_UP_DELAY_TIMER)
        else $error("unprogrammed enable bit started the delay");
    a_master_clear_input_run: assert property (
        (state == ST_RUN && master_clear_input_event)
        |=> reg_reset && reset_cause == CAUSE_MASTER_CLEAR_INPUT_RUN)
        else $error("master-clear reset not recorded");
    a_cfg_locked: assert property (
        !prog_mode |=> $stable(cfg_word))
        else $error("config word changed outside programming");
    a_cal_kept: assert property (
        (prog_mode && prog_bulk_erase) |=> $stable(cal_word))
        else $error("bulk erase touched calibration word");
endmodule : rss_reset_sequencer

// ---- rtl/rss_pkg.sv ----
// Shared constants and types of the reset and start-up sequencer.
// Assumes a single 200 MHz clock; every count below is in clk cycles.
package rss_pkg;

    // ==========================================================
    // Clock and delay figures
    localparam int CLK_KHZ         = 200_000;
    localparam int POWER_UP_DELAY_TIMER_TIME_MS    = 64;
    localparam int POWER_UP_DELAY_TIMER_CYCLES     = POWER_UP_DELAY_TIMER_TIME_MS * CLK_KHZ;
    localparam int OST_CYCLES      = 1024;
    localparam int MASTER_CLEAR_INPUT_MIN_NS     = 2000;
    localparam int MASTER_CLEAR_INPUT_CYCLES     =
        (MASTER_CLEAR_INPUT_MIN_NS * (CLK_KHZ / 1000) + 999) / 1000;
    localparam int BOR_QUAL_US     = 100;
    localparam int BOR_QUAL_CYCLES = BOR_QUAL_US * (CLK_KHZ / 1000);

    // ==========================================================
    // Configuration space
    localparam logic [13:0] CFG_WORD_ADDR = 14'h2007;
    localparam logic [13:0] CAL_WORD_ADDR = 14'h2008;
    localparam logic [13:0] WORD_ERASED   = 14'h3FFF;
    localparam logic [13:0] WORD_ZERO     = 14'h0000;
    localparam int          CFG_XTAL_BIT  = 0;
    localparam int          CFG_POWER_UP_DELAY_ENABLE_BIT = 4;
    localparam int          CFG_BOREN_LO  = 8;
    localparam int          CFG_BOREN_HI  = 9;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        BOR_OFF     = 2'h0,
        BOR_SW      = 2'h1,
        BOR_NOSLEEP = 2'h2,
        BOR_ON      = 2'h3
    } rss_bor_mode_t;

    typedef enum logic [2:0] {
        CAUSE_POR        = 3'h0,
        CAUSE_WDT_RUN    = 3'h1,
        CAUSE_WDT_SLEEP  = 3'h2,
        CAUSE_MASTER_CLEAR_INPUT_RUN   = 3'h3,
        CAUSE_MASTER_CLEAR_INPUT_SLEEP = 3'h4,
        CAUSE_BOR        = 3'h5,
        CAUSE_INT_WAKE   = 3'h6
    } rss_cause_t;

    typedef enum logic [2:0] {
        ST_SUPPLY = 3'h0,
        ST_POWER_UP_DELAY_TIMER   = 3'h1,
        ST_OST    = 3'h2,
        ST_RUN    = 3'h3,
        ST_SLEEP  = 3'h4
    } rss_state_t;

endpackage : rss_pkg

// ---- rtl/rss_tmr_if.sv ----
// Run/done handshake between the sequencer and one delay timer.
// Assumes both ends share clk.
`timescale 1ns/1ps
interface rss_tmr_if (
    input wire logic clk
);
    logic run;
    logic done;

    modport ctl (output run, input done);
    modport tmr (input clk, input run, output done);
endinterface : rss_tmr_if

// ---- rtl/rss_delay_timer.sv ----
// Delay counter: done rises after run has been high COUNT cycles.
// Assumes run stays high until done is seen; dropping run restarts.
`timescale 1ns/1ps
module rss_delay_timer
    import rss_pkg::*;
#(
    parameter int unsigned COUNT = 1
) (
    rss_tmr_if.tmr   t,
    input wire logic rst_b
);
    logic [31:0] cnt;

    // ==========================================================
    // Counter
    always_ff @(posedge t.clk) begin
        if (!rst_b || !t.run) begin
            cnt <= '0;
        end else if (cnt != COUNT) begin
            cnt <= cnt + 32'h1;
        end
    end

    assign t.done = t.run && (cnt == COUNT);

    // ==========================================================
    // Checks
    a_done_needs_run: assert property (@(posedge t.clk) disable iff (!rst_b)
        t.done |-> $past(t.run) && t.run)
        else $error("timer done without a running count");
endmodule : rss_delay_timer

// ---- rtl/rss_pulse_filter.sv ----
// Pulse filter: output goes high only after WIDTH high samples in a row.
// Assumes level_in is synchronous to clk; output falls one cycle late.
`timescale 1ns/1ps
module rss_pulse_filter #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic level_in,
    output logic      level_out
);
    logic [31:0] cnt;

    // ==========================================================
    // Width counter
    always_ff @(posedge clk) begin
        if (!rst_b || !level_in) begin
            cnt <= '0;
        end else if (cnt != WIDTH) begin
            cnt <= cnt + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            level_out <= 1'b0;
        end else begin
            level_out <= level_in && (cnt >= WIDTH - 1);
        end
    end

    // ==========================================================
    // Checks
    a_short_dropped: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(level_out) |-> $past(cnt) == WIDTH - 1)
        else $error("filter passed a pulse that was too short");
endmodule : rss_pulse_filter

// ---- verification/rss_reset_sequencer_tb_top.sv ----
// Self-checking bench of the reset and start-up sequencer.
// Assumes shortened delay counts; the bench drives every pin itself.
`timescale 1ns/1ps
module rss_reset_sequencer_tb_top
    import rss_pkg::*;
();
    // ======================================================
    // Set-up
    localparam int PW = 20;
    localparam int OS = 8;
    localparam int BQ = 4;
    localparam int MC = 3;
    logic        clk, rst_b, clear_pin_b, supply, dog_ev, sleep_en;
    logic        int_wake, kick, sw_bo_en, prog_mode, prog_wr, erase;
    logic [13:0] addr, wdata, rdata;
    logic        core_reset, reg_reset, sleeping, bo_act, tmo_f, pdn_f;
    rss_cause_t  cause;
    logic [31:0] lfsr;
    logic [1:0]  flg;
    logic        reg_seen;
    int          fails, comparisons, n0, n1, n2, n3;

    rss_reset_sequencer #(
        .POWER_UP_DELAY_TIMER_COUNT (PW),
        .OST_COUNT  (OS),
        .BOR_COUNT  (BQ),
        .MASTER_CLEAR_INPUT_COUNT (MC)
    ) u_rss_reset_sequencer (
        .clk                    (clk),
        .rst_b                  (rst_b),
        .master_clear_input_b   (clear_pin_b),
        .supply_above_threshold (supply),
        .watchdog_timer_event   (dog_ev),
        .sleep_enter            (sleep_en),
        .interrupt_wake         (int_wake),
        .clear_watchdog_cmd     (kick),
        .sw_brown_out_enable    (sw_bo_en),
        .prog_mode              (prog_mode),
        .prog_write             (prog_wr),
        .prog_bulk_erase        (erase),
        .prog_addr              (addr),
        .prog_wdata             (wdata),
        .prog_rdata             (rdata),
        .core_reset             (core_reset),
        .reg_reset              (reg_reset),
        .core_sleeping          (sleeping),
        .brown_out_active       (bo_act),
        .time_out_flag          (tmo_f),
        .power_down_flag        (pdn_f),
        .reset_cause            (cause)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Sticky so a one-cycle register reset on a wake path is not missed
    always @(posedge clk) if (reg_reset === 1'b1) reg_seen <= 1'b1;

    // ======================================================
    // Expectations
    function automatic logic [31:0] lfsr_next(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    function automatic logic [13:0] cfg(logic xt, logic pu, logic [1:0] m);
        logic [13:0] w;
        w = WORD_ERASED;
        w[CFG_XTAL_BIT] = ~xt;
        w[CFG_POWER_UP_DELAY_ENABLE_BIT] = ~pu;
        w[CFG_BOREN_HI:CFG_BOREN_LO] = m;
        return w;
    endfunction : cfg

    function automatic logic [1:0] next_flags(rss_cause_t c, logic [1:0] f);
        case (c)
            CAUSE_WDT_RUN:    return {1'b0, f[0]};
            CAUSE_WDT_SLEEP:  return 2'b00;
            CAUSE_MASTER_CLEAR_INPUT_RUN:   return f;
            CAUSE_MASTER_CLEAR_INPUT_SLEEP: return 2'b10;
            CAUSE_INT_WAKE:   return 2'b10;
            default:          return 2'b11;
        endcase
    endfunction : next_flags

    function automatic logic bo_exp(int m, logic sw, logic slp);
        case (m)
            3:       return 1'b1;
            2:       return ~slp;
            1:       return sw;
            default: return 1'b0;
        endcase
    endfunction : bo_exp

    // ======================================================
    // Compare and drive tasks
    task automatic check_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_word(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_cause(input rss_cause_t got, input rss_cause_t exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_cause

    task automatic expect_cause(input rss_cause_t c);
        flg = next_flags(c, flg);
        check_cause(cause, c);
        check_bit(tmo_f, flg[1]);
        check_bit(pdn_f, flg[0]);
    endtask : expect_cause

    task automatic set(input int s, input logic v);
        case (s)
            0:       clear_pin_b <= ~v;
            1:       supply <= ~v;
            2:       dog_ev <= v;
            3:       sleep_en <= v;
            4:       kick <= v;
            default: int_wake <= v;
        endcase
    endtask : set

    task automatic hold(input int s, input int n);
        @(posedge clk);
        set(s, 1'b1);
        repeat (n) @(posedge clk);
        set(s, 1'b0);
    endtask : hold

    task automatic wait_core(input logic v, output int n);
        n = 0;
        while (core_reset !== v && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        check_bit(core_reset, v);
    endtask : wait_core

    task automatic wake_wait;
        for (int k = 0; k < 50 && sleeping !== 1'b0; k++) @(posedge clk);
        #1;
        check_bit(sleeping, 1'b0);
    endtask : wake_wait

    task automatic quiet_check;
        repeat (4) @(posedge clk);
        #1;
        check_bit(core_reset, 1'b0);
    endtask : quiet_check

    task automatic prog(input logic [13:0] a, input logic [13:0] d,
                        input logic bulk);
        @(posedge clk);
        prog_mode <= 1'b1;
        addr      <= a;
        wdata     <= d;
        prog_wr   <= ~bulk;
        erase     <= bulk;
        @(posedge clk);
        prog_wr   <= 1'b0;
        erase     <= 1'b0;
    endtask : prog

    task automatic rd(input logic [13:0] a, input logic [13:0] exp);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
        check_word(rdata, exp);
    endtask : rd

    // Config words have no reset, so they are written before supply rises
    task automatic power_up(input logic [13:0] w, input int dip, output int n);
        @(posedge clk);
        rst_b  <= 1'b0;
        supply <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        check_bit(core_reset & reg_reset, 1'b1);
        check_bit(tmo_f & pdn_f & ~sleeping, 1'b1);
        check_cause(cause, CAUSE_POR);
        @(posedge clk);
        rst_b     <= 1'b1;
        // Enter programming at release so the unset config is never idle
        prog_mode <= 1'b1;
        prog(CFG_WORD_ADDR, w, 1'b0);
        @(posedge clk);
        prog_mode <= 1'b0;
        supply    <= 1'b1;
        if (dip > 0) begin
            repeat (dip) @(posedge clk);
            supply <= 1'b0;
            repeat (2) @(posedge clk);
            supply <= 1'b1;
        end
        wait_core(1'b0, n);
        flg = 2'b11;
    endtask : power_up

    task automatic summarize;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : summarize

    // ======================================================
    // Scenarios
    initial begin
        {dog_ev, sleep_en, int_wake, kick, sw_bo_en} = '0;
        {rst_b, supply, prog_mode, prog_wr, erase} = '0;
        {addr, wdata} = '0;
        clear_pin_b = 1'b1;
        lfsr = 32'hFEAEE5D0;
        {fails, comparisons} = '0;
        flg = 2'b11;
        reg_seen = 1'b0;
        power_up(cfg(1'b1, 1'b1, 2'h3), 0, n0);
        power_up(cfg(1'b0, 1'b1, 2'h3), 0, n1);
        check_bit(n0 - n1 >= OS + 1 && n0 - n1 <= OS + 2, 1'b1);
        power_up(cfg(1'b0, 1'b0, 2'h3), 0, n2);
        check_bit(n1 - n2 >= PW + 1 && n1 - n2 <= PW + 2, 1'b1);
        lfsr = lfsr_next(lfsr);
        power_up(cfg(1'b0, 1'b1, 2'h3), 3 + lfsr % (PW - 6), n3);
        check_bit(n3 == n1, 1'b1);
        lfsr = lfsr_next(lfsr);
        hold(1, 1 + lfsr % (BQ - 1));
        quiet_check();
        hold(1, BQ + 3);
        wait_core(1'b0, n0);
        expect_cause(CAUSE_BOR);
        hold(0, MC - 1);
        quiet_check();
        hold(0, MC + 3);
        check_bit(reg_reset, 1'b1);
        wait_core(1'b0, n0);
        expect_cause(CAUSE_MASTER_CLEAR_INPUT_RUN);
        hold(2, 1);
        wait_core(1'b1, n0);
        check_bit(reg_reset, 1'b1);
        wait_core(1'b0, n0);
        expect_cause(CAUSE_WDT_RUN);
        hold(4, 1);
        repeat (2) @(posedge clk);
        #1;
        check_bit(tmo_f & pdn_f, 1'b1);
        for (int i = 0; i < 3; i++) begin
            hold(3, 1);
            repeat (2) @(posedge clk);
            #1;
            check_bit(sleeping & tmo_f & ~pdn_f, 1'b1);
            flg = 2'b10;
            reg_seen = 1'b0;
            hold(i == 0 ? 5 : (i == 1 ? 2 : 0), i == 2 ? MC + 3 : 1);
            wake_wait();
            wait_core(1'b0, n0);
            expect_cause(i == 0 ? CAUSE_INT_WAKE : (i == 1 ?
                CAUSE_WDT_SLEEP : CAUSE_MASTER_CLEAR_INPUT_SLEEP));
            check_bit(reg_seen, i == 2);
        end
        for (int m = 0; m < 4; m++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            sw_bo_en <= lfsr[0];
            power_up(cfg(1'b0, 1'b0, m[1:0]), 0, n0);
            repeat (2) @(posedge clk);
            #1;
            check_bit(bo_act, bo_exp(m, lfsr[0], 1'b0));
            hold(3, 1);
            repeat (3) @(posedge clk);
            #1;
            check_bit(bo_act, bo_exp(m, lfsr[0], 1'b1));
            hold(5, 1);
            wake_wait();
            repeat (3) @(posedge clk);
            #1;
            check_bit(bo_act, bo_exp(m, lfsr[0], 1'b0));
        end
        lfsr = lfsr_next(lfsr);
        prog(CAL_WORD_ADDR, lfsr[13:0], 1'b0);
        rd(CAL_WORD_ADDR, lfsr[13:0]);
        prog(CFG_WORD_ADDR, WORD_ZERO, 1'b1);
        rd(CFG_WORD_ADDR, WORD_ERASED);
        rd(CAL_WORD_ADDR, lfsr[13:0]);
        @(posedge clk);
        prog_mode <= 1'b0;
        rd(CFG_WORD_ADDR, WORD_ZERO);
        summarize();
    end

    // Whole run needs about 400 cycles; this cuts a hang short
    initial begin
        #100000;
        fails++;
        summarize();
    end
endmodule : rss_reset_sequencer_tb_top
